// ---- rtl/agclf_loop_filter.sv ----
module agclf_loop_filter (
	input  wire logic        REF_CLK_IN,
	input  wire logic        SYS_RST_IN,
	input  wire logic        MAG_VALID_IN,
	input  wire logic [agclf_pkg::THR_W-1:0] MAG_IN,
	input  wire logic [31:0] LOOP_PARAM_WORD_IN,
	input  wire logic [31:0] GAIN_LIMIT_WORD_IN,
	input  wire logic [31:0] MODE_WORD_IN,
	input  wire logic        BACKEND_RESET_IN,
	input  wire logic        LOOP_GAIN_SELECT_IN,
	output logic [3:0]       GAIN_EXP_OUT,
	output logic [11:0]      GAIN_MANT_OUT
);
	import agclf_pkg::*;

	logic                      gain_sel;
	logic [LG_W-1:0]           lg;
	logic [3:0]                lg_mant;
	logic [3:0]                lg_exp;
	logic [3:0]                shift;
	logic [THR_W-1:0]          magnitude_threshold;
	logic signed [ERR_W-1:0]   true_err;
	logic signed [ERR_W-1:0]   err;
	logic signed [PROD_W-1:0]  prod;
	logic signed [SUM_W-1:0]   delta;
	logic signed [SUM_W-1:0]   sum;
	logic [ACC_W-1:0]          upper;
	logic [ACC_W-1:0]          lower;
	logic [ACC_W-1:0]          clamped;
	logic                      median;
	logic                      keep;
	logic [ACC_W-1:0]          acc_q;
	logic [ACC_W-1:0]          acc_d;

	agclf_sync u_sel_sync (
		.REF_CLK_IN (REF_CLK_IN),
		.SYS_RST_IN (SYS_RST_IN),
		.async_in   (LOOP_GAIN_SELECT_IN),
		.sync_out   (gain_sel)
	);

	always_comb begin
		median = MODE_WORD_IN[MODE_MED];
		keep   = MODE_WORD_IN[MODE_KEEP];
		// both sets live in the low half of the word
		lg = gain_sel ? LOOP_PARAM_WORD_IN[LG1_LSB +: LG_W]
		              : LOOP_PARAM_WORD_IN[LG0_LSB +: LG_W];
		lg_mant = lg[LGM_MSB:0];
		lg_exp  = lg[LGE_MSB:LGE_LSB];
		shift   = SHIFT_MAX - lg_exp;
		magnitude_threshold  = LOOP_PARAM_WORD_IN[THR_MSB:THR_LSB];
		true_err = ERR_W'(signed'({1'b0, magnitude_threshold}))
		         - ERR_W'(signed'({1'b0, MAG_IN}));
		// zero error counts as the upward direction
		if (median)
			err = true_err[ERR_W-1] ? MED_NEG : MED_POS;
		else
			err = true_err;
		// mantissa has four fraction bits, so code/16
		prod  = PROD_W'(err) * PROD_W'(signed'({1'b0, lg_mant}));
		delta = (SUM_W'(prod) <<< PROD_ALIGN) >>> shift;
		sum   = SUM_W'(signed'({1'b0, acc_q})) + delta;
		// limits are compared as aligned gain words
		upper = {GAIN_LIMIT_WORD_IN[LIM_HI_LSB +: LIM_W],
		         {LIM_PAD{1'b0}}};
		lower = {GAIN_LIMIT_WORD_IN[LIM_LO_LSB +: LIM_W],
		         {LIM_PAD{1'b0}}};
		if (sum > SUM_W'(signed'({1'b0, upper})))
			clamped = upper;
		else if (sum < SUM_W'(signed'({1'b0, lower})))
			clamped = lower;
		else
			clamped = sum[ACC_W-1:0];
		// a clearing reset (keep bit low) outranks a sample arriving in the same cycle
		if (BACKEND_RESET_IN && !keep)
			acc_d = ACC_RST;
		else if (MAG_VALID_IN)
			acc_d = clamped;
		else
			acc_d = acc_q;
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN)
			acc_q <= ACC_RST;
		else
			acc_q <= acc_d;
	end

	// gain stage samples these whenever its data advances
	assign GAIN_EXP_OUT  = acc_q[ACC_E_MSB:ACC_E_LSB];
	assign GAIN_MANT_OUT = acc_q[ACC_M_MSB:ACC_M_LSB];

	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);

	property p_hold;
		!MAG_VALID_IN && !BACKEND_RESET_IN |=> $stable(acc_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("accumulator moved without a sample");

	property p_clear;
		BACKEND_RESET_IN && !MODE_WORD_IN[MODE_KEEP] |=> acc_q == ACC_RST;
	endproperty
	a_clear: assert property (p_clear)
		else $error("backend reset did not clear accumulator");

	property p_keep;
		BACKEND_RESET_IN && MODE_WORD_IN[MODE_KEEP] && !MAG_VALID_IN
		|=> $stable(acc_q);
	endproperty
	a_keep: assert property (p_keep)
		else $error("preserved accumulator was disturbed");

	property p_upper;
		MAG_VALID_IN && !BACKEND_RESET_IN && lower <= upper
		|=> acc_q <= $past(upper);
	endproperty
	a_upper: assert property (p_upper)
		else $error("accumulator above upper limit");

	property p_lower;
		MAG_VALID_IN && !BACKEND_RESET_IN && lower <= upper
		|=> acc_q >= $past(lower);
	endproperty
	a_lower: assert property (p_lower)
		else $error("accumulator below lower limit");

	property p_median_err;
		median |-> (err == (true_err < 0 ? MED_NEG : MED_POS));
	endproperty
	a_median_err: assert property (p_median_err)
		else $error("median error not fixed by sign");

	property p_mean_err;
		!median |-> err == ERR_W'(signed'({1'b0, magnitude_threshold}))
		               - ERR_W'(signed'({1'b0, MAG_IN}));
	endproperty
	a_mean_err: assert property (p_mean_err)
		else $error("mean error not threshold minus magnitude");

	property p_zero_gain;
		MAG_VALID_IN && !BACKEND_RESET_IN && lg_mant == 4'h0
		&& acc_q >= lower && acc_q <= upper |=> $stable(acc_q);
	endproperty
	a_zero_gain: assert property (p_zero_gain)
		else $error("zero loop gain changed accumulator");

	property p_full_shift;
		lg_exp == 4'h0 |-> shift == SHIFT_MAX;
	endproperty
	a_full_shift: assert property (p_full_shift)
		else $error("exponent zero must shift by fifteen");

	sequence s_sel_high;
		LOOP_GAIN_SELECT_IN [*4];
	endsequence
	sequence s_sel_low;
		!LOOP_GAIN_SELECT_IN [*4];
	endsequence
	property p_sel_high;
		s_sel_high |=> gain_sel
		&& lg == LOOP_PARAM_WORD_IN[LG1_LSB +: LG_W];
	endproperty
	a_sel_high: assert property (p_sel_high)
		else $error("gain set one not selected");
	property p_sel_low;
		s_sel_low |=> !gain_sel
		&& lg == LOOP_PARAM_WORD_IN[LG0_LSB +: LG_W];
	endproperty
	a_sel_low: assert property (p_sel_low)
		else $error("gain set zero not selected");

	property p_update;
		MAG_VALID_IN && !BACKEND_RESET_IN
		&& sum >= SUM_W'(signed'({1'b0, lower}))
		&& sum <= SUM_W'(signed'({1'b0, upper}))
		|=> acc_q == $past(sum[ACC_W-1:0]);
	endproperty
	a_update: assert property (p_update)
		else $error("accumulator did not add scaled error");

	property p_reset_wins;
		BACKEND_RESET_IN && !MODE_WORD_IN[MODE_KEEP] && MAG_VALID_IN
		|=> acc_q == ACC_RST;
	endproperty
	a_reset_wins: assert property (p_reset_wins)
		else $error("sample beat a clearing backend reset");

	property p_mean_settled;
		MAG_VALID_IN && !BACKEND_RESET_IN && !median
		&& MAG_IN == magnitude_threshold && acc_q >= lower && acc_q <= upper
		|=> $stable(acc_q);
	endproperty
	a_mean_settled: assert property (p_mean_settled)
		else $error("zero mean error moved the accumulator");

	// mantissa below sixteen keeps a median step under this weight
	localparam logic signed [SUM_W-1:0] MED_STEP_LIM =
		SUM_W'(MED_POS) <<< (PROD_ALIGN + $bits(lg_mant));
	sequence s_med_sample;
		median && MAG_VALID_IN && !BACKEND_RESET_IN;
	endsequence
	property p_median_step;
		s_med_sample
		|-> delta < MED_STEP_LIM && delta > -MED_STEP_LIM;
	endproperty
	a_median_step: assert property (p_median_step)
		else $error("median step exceeds its bound");

	// a reset edge may drop the select without the pin settling
	property p_sel_filtered;
		$changed(gain_sel) && !$past(SYS_RST_IN)
		|-> $past(LOOP_GAIN_SELECT_IN, 3) == gain_sel
		&& $past(LOOP_GAIN_SELECT_IN, 4) == gain_sel;
	endproperty
	a_sel_filtered: assert property (p_sel_filtered)
		else $error("gain select changed before pin settled");

	property p_out_next;
		MAG_VALID_IN && !BACKEND_RESET_IN
		|=> {GAIN_EXP_OUT, GAIN_MANT_OUT}
		    == $past(clamped[ACC_E_MSB:ACC_M_LSB]);
	endproperty
	a_out_next: assert property (p_out_next)
		else $error("gain outputs did not follow the sample");
endmodule

// ---- rtl/agclf_pkg.sv ----
// Function
// - upper gain limit: exponent 27-24, mantissa 23-16
// - loop gain mantissa code means code/16
// - loop gain exponent code 0 shifts 15
// - both loop gain sets in low 16 bits
// - select pin low set0, high set1
// - preserve bit 15 keeps accumulator on backend reset
// - mean mode adds scaled threshold minus magnitude
// - mode bit 16 one selects median mode
// - median error fixed by true error sign
// - median error scaled by selected loop gain
// - gain step follows error times loop gain
// - median step bounded near 1.5 dB
// - running accumulator drives data path gain
// - error equals threshold minus magnitude
// - accumulator clamped between lower, upper limits
// - upper limit 27-16, lower limit 11-0
// - gain value sampled by multiplier per sample
package agclf_pkg;
	localparam int ACC_W      = 31;
	localparam int SUM_W      = 34;
	localparam int ERR_W      = 14;
	localparam int THR_W      = 13;
	localparam int LIM_W      = 12;
	localparam int LG_W       = 8;
	localparam int PROD_W     = 19;
	// threshold field in the loop parameter word
	localparam int THR_LSB    = 16;
	localparam int THR_MSB    = 28;
	// two loop gain sets, mantissa low nibble
	localparam int LG0_LSB    = 0;
	localparam int LG1_LSB    = 8;
	localparam int LGM_MSB    = 3;
	localparam int LGE_LSB    = 4;
	localparam int LGE_MSB    = 7;
	// limit word fields
	localparam int LIM_HI_LSB = 16;
	localparam int LIM_LO_LSB = 0;
	// mode word bits
	localparam int MODE_KEEP  = 15;
	localparam int MODE_MED   = 16;
	// accumulator layout: exponent then mantissa
	localparam int ACC_E_MSB  = 30;
	localparam int ACC_E_LSB  = 27;
	localparam int ACC_M_MSB  = 26;
	localparam int ACC_M_LSB  = 15;
	localparam int LIM_PAD    = 19;
	// error lsb lands on accumulator bit 15 at unity
	localparam int PROD_ALIGN = 11;
	localparam logic [3:0] SHIFT_MAX = 4'hF;
	localparam logic signed [ERR_W-1:0] MED_POS = 14'sh0200;
	localparam logic signed [ERR_W-1:0] MED_NEG = 14'sh3E00;
	localparam logic [ACC_W-1:0] ACC_RST = 31'h00000000;
endpackage

// ---- rtl/agclf_sync.sv ----
module agclf_sync (
	input  wire logic REF_CLK_IN,
	input  wire logic SYS_RST_IN,
	input  wire logic async_in,
	output logic      sync_out
);
	logic s1_q, s2_q, s3_q, out_q;
	logic s1_d, s2_d, s3_d, out_d;

	// change accepted only once stages two and three agree
	always_comb begin
		s1_d  = async_in;
		s2_d  = s1_q;
		s3_d  = s2_q;
		out_d = (s2_q == s3_q) ? s3_q : out_q;
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			out_q <= 1'b0;
		end else begin
			s1_q  <= s1_d;
			s2_q  <= s2_d;
			s3_q  <= s3_d;
			out_q <= out_d;
		end
	end

	assign sync_out = out_q;
endmodule

// ---- bench/agclf_mag_src.sv ----
module agclf_mag_src (
	input  wire logic        clk_in,
	output logic             valid_out,
	output logic [12:0]      mag_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		valid_out = 1'b0;
		mag_out = 13'h0000;
	end
	// one sample per call, presented at the falling edge
	task automatic send(input logic [12:0] m);
		valid_out = 1'b1;
		mag_out = m;
		@(negedge clk_in);
	endtask
	// stale data is inverted so nothing can lean on it
	task automatic idle();
		valid_out = 1'b0;
		mag_out = ~mag_out;
	endtask
endmodule

// ---- bench/agc_loop_filter_test.sv ----
module agc_loop_filter_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        bres = 1'b0;
	logic        sel = 1'b0;
	logic [31:0] lp = 32'h0400_00FF;
	logic [31:0] lim = 32'h0FFF_0000;
	logic [31:0] md = 32'h0000_0000;
	logic        vld;
	logic [12:0] mag;
	logic [3:0]  g_e;
	logic [11:0] g_m;
	logic [30:0] acc = 31'h0;
	int          fails = 0;
	int          n_checks = 0;
	int          cyc = 0;

	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			test_done();
		end
	end

	agclf_mag_src mag_u (.clk_in(clk), .valid_out(vld), .mag_out(mag));
	agclf_loop_filter dut_u (
		.REF_CLK_IN          (clk),
		.SYS_RST_IN          (rst),
		.MAG_VALID_IN        (vld),
		.MAG_IN              (mag),
		.LOOP_PARAM_WORD_IN  (lp),
		.GAIN_LIMIT_WORD_IN  (lim),
		.MODE_WORD_IN        (md),
		.BACKEND_RESET_IN    (bres),
		.LOOP_GAIN_SELECT_IN (sel),
		.GAIN_EXP_OUT        (g_e),
		.GAIN_MANT_OUT       (g_m)
	);

	function automatic logic [30:0] nxt(input logic [12:0] m);
		logic [7:0]         g;
		logic signed [13:0] e;
		logic signed [33:0] d, hi, lo;
		g = sel ? lp[15:8] : lp[7:0];
		if (md[16])
			e = (lp[28:16] >= m) ? 14'sh0200 : 14'sh3E00;
		else
			e = $signed({1'b0, lp[28:16]}) - $signed({1'b0, m});
		d = e * $signed({1'b0, g[3:0]});
		d = (d <<< 11) >>> (4'hF - g[7:4]);
		d = d + $signed({3'h0, acc});
		hi = $signed({3'h0, lim[27:16], 19'h0});
		lo = $signed({3'h0, lim[11:0], 19'h0});
		if (d > hi)
			d = hi;
		if (d < lo)
			d = lo;
		return d[30:0];
	endfunction

	task automatic chk(input string nm, input logic [15:0] x);
		n_checks++;
		if ({g_e, g_m} !== x) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, x, {g_e, g_m});
		end
	endtask
	// settle two edges so either output latency is covered
	task automatic smp(input logic [12:0] m);
		mag_u.send(m);
		mag_u.idle();
		@(negedge clk);
		acc = nxt(m);
	endtask

	task automatic t_mean();
		smp(13'h0000);
		chk("mean up", acc[30:15]);
		smp(13'h0600);
		chk("mean down", acc[30:15]);
		smp(13'h0400);
		chk("mean zero", acc[30:15]);
		repeat (5) @(negedge clk);
		chk("hold", acc[30:15]);
		for (int i = 0; i < 16; i++) begin
			lp[7:0] = {i[3:0], i[3:0]};
			smp(13'h0100);
			chk("code", acc[30:15]);
		end
	endtask
	task automatic t_limits();
		lim = 32'h0123_0045;
		lp[7:0] = 8'hFF;
		// enough full steps to reach the ceiling from any start
		repeat (80) smp(13'h0000);
		chk("upper", 16'h1230);
		chk("upper model", acc[30:15]);
		repeat (3) smp(13'h1FFF);
		chk("lower", 16'h0450);
		lim = 32'h0FFF_0000;
	endtask
	// small tracking set one first, then back to the fast set zero
	task automatic t_select();
		lp[15:8] = 8'h01;
		sel = 1'b1;
		repeat (6) @(negedge clk);
		smp(13'h0000);
		chk("set one", acc[30:15]);
		sel = 1'b0;
		repeat (6) @(negedge clk);
		smp(13'h0000);
		chk("set zero", acc[30:15]);
	endtask
	task automatic t_median();
		md[16] = 1'b1;
		smp(13'h03FF);
		chk("med pos", acc[30:15]);
		smp(13'h0400);
		chk("med zero", acc[30:15]);
		smp(13'h1FFF);
		chk("med neg", acc[30:15]);
		md[16] = 1'b0;
	endtask
	task automatic t_bres(input logic keep);
		md[15] = keep;
		bres = 1'b1;
		@(negedge clk);
		if (!keep)
			acc = 31'h0;
		chk("backend reset", acc[30:15]);
		// a sample inside the pulse is kept only when preserving
		if (keep)
			acc = nxt(13'h0000);
		mag_u.send(13'h0000);
		bres = 1'b0;
		mag_u.idle();
		@(negedge clk);
		chk("reset with sample", acc[30:15]);
	endtask
	// mid-run reset must drop a grown gain, then samples resume
	task automatic t_sysrst();
		smp(13'h0000);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		acc = 31'h0;
		chk("system reset", acc[30:15]);
		smp(13'h0000);
		chk("after reset", acc[30:15]);
	endtask

	task automatic test_done();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk("reset", 16'h0000);
		t_mean();
		t_limits();
		t_select();
		t_median();
		t_sysrst();
		t_bres(1'b1);
		t_bres(1'b0);
		test_done();
	end
endmodule
